// file: hw/msr_regs.svh
// Contract
// - Speed-detect bits 16-13 hold brake duration code, 10 ms to 15 s.
// - Speed-detect bits 12-9 hold float duration code, same scale.
// - Speed-detect bits 8-6 pick standstill EMF threshold, 100 to 3000 mV.
// - Speed-detect bits 5-2 pick reverse handoff speed, 2.5% to 100%.
// - Speed-detect bits 1-0 pick reverse open-loop current, 15% to 50%.
// - Reverse-drive bits 30-27 hold linear accel code, 0.01 to 10000 Hz/s.
// - Reverse-drive bits 26-23 hold quadratic accel code, zero means none.
// - Reverse-drive bits 22-20 pick braking current limit, 10% to 80%.
// - Reverse-drive bits 19-10 hold braking proportional gain, value/2^7.
// - Reverse-drive bits 9-0 hold braking integral gain, value/2^9.
// - Startup bits 30-29 select method: align, double, position detect, slow.
// - Startup bits 28-25 set current ramp rate; code F means no limit.
// - Startup bits 24-21 set align hold time, 10 ms to 10 s.
// - Brake phase applies only when speed-detect bit 29 is set.
// - Float phase applies only when speed-detect bit 28 is set.
// - Reverse-drive settings apply only when speed-detect bit 27 is set; the code gates bits 30-23 only and passes braking bits 22-0 through.
`ifndef MSR_REGS_SVH
`define MSR_REGS_SVH
// Word indices; the byte address on the bus is four times the index
`define MSR_IDX_SD       8'h80
`define MSR_IDX_RD       8'h82
`define MSR_IDX_SU       8'h84
`define MSR_IDX_HI       9
`define MSR_IDX_LO       2
`define MSR_RESET        32'h0000_0000
`define MSR_BRK_EN_BIT   29
`define MSR_FLT_EN_BIT   28
`define MSR_REV_EN_BIT   27
`define MSR_QACC_DUP     4'hE
`define MSR_RAMP_DUP_LO  4'hC
`define MSR_RAMP_FREE    4'hF
`define MSR_RAMP_DUP_HI  4'hE
`define MSR_HSIZE_WORD   3'h2
`endif

// file: hw/msr_pkg.sv
package msr_pkg;
    typedef struct packed {
        logic       parity;
        logic       speed_detect_enable;
        logic       brake_enable;
        logic       float_phase_enable;
        logic       reverse_drive_enable;
        logic       resync_enable;
        logic [3:0] resync_speed;
        logic       rsvd;
        logic [3:0] blanking;
        logic [3:0] brake_hold_duration;
        logic [3:0] float_duration;
        logic [2:0] standstill_emf_threshold;
        logic [3:0] reverse_handoff_speed;
        logic [1:0] reverse_open_loop_current_limit;
    } msr_sd_t;
    typedef struct packed {
        logic       parity;
        logic [3:0] reverse_linear_accel;
        logic [3:0] reverse_quadratic_accel;
        logic [2:0] braking_current_limit;
        logic [9:0] braking_prop_gain;
        logic [9:0] braking_integral_gain;
    } msr_rd_t;
    typedef struct packed {
        logic       parity;
        logic [1:0] startup_method;
        logic [3:0] ramp_rate;
        logic [3:0] align_time;
        logic [20:0] rest;
    } msr_su_t;
    typedef enum logic [1:0] {
        MSR_ST_ALIGN  = 2'h0,
        MSR_ST_DOUBLE = 2'h1,
        MSR_ST_IRPD   = 2'h2,
        MSR_ST_SLOW   = 2'h3
    } msr_startup_t;
    typedef struct packed {
        logic       brake_active;
        logic [3:0] brake_hold_duration;
        logic       float_active;
        logic [3:0] float_duration;
        logic [2:0] standstill_emf_threshold;
        logic       reverse_active;
        logic [3:0] reverse_handoff_speed;
        logic [1:0] reverse_open_loop_current_limit;
        logic [3:0] reverse_linear_accel;
        logic [3:0] reverse_quadratic_accel;
        logic [2:0] braking_current_limit;
        logic [9:0] braking_prop_gain;
        logic [9:0] braking_integral_gain;
        msr_startup_t startup_method;
        logic [3:0] ramp_rate;
        logic       ramp_unlimited;
        logic [3:0] align_time;
        logic       code_unresolved;
    } msr_cfg_t;
endpackage : msr_pkg

// file: hw/msr_bank.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "msr_regs.svh"
module msr_bank (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    output msr_pkg::msr_cfg_t     cfg
);
    import msr_pkg::*;

    msr_sd_t    sd;
    msr_rd_t    rd;
    msr_su_t    su;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       take;
    logic [7:0] a8;

    assign take = hsel && hready && htrans[1];
    assign a8   = haddr[`MSR_IDX_HI:`MSR_IDX_LO];

    // Zero-wait slave; writes land at the data-phase end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take && hwrite && hsize == `MSR_HSIZE_WORD;
            wr_addr <= a8;
        end
    end

    // Whole-word stores; parity bit kept as plain data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd <= `MSR_RESET;
            rd <= `MSR_RESET;
            su <= `MSR_RESET;
        end else if (wr_pend) begin
            if (wr_addr == `MSR_IDX_SD) sd <= hwdata;
            if (wr_addr == `MSR_IDX_RD) rd <= hwdata;
            if (wr_addr == `MSR_IDX_SU) su <= hwdata;
        end
    end

    // Read data registered at address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            unique case (a8)
                `MSR_IDX_SD: hrdata <= sd;
                `MSR_IDX_RD: hrdata <= rd;
                `MSR_IDX_SU: hrdata <= su;
                default:      hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    msr_cfg_t next_cfg;

    // Gated views for the algorithm; codes pass through, scaling lives there
    always_comb begin
        next_cfg = '0;
        next_cfg.brake_active = sd.brake_enable;
        next_cfg.brake_hold_duration = sd.brake_hold_duration;
        next_cfg.float_active = sd.float_phase_enable;
        next_cfg.float_duration = sd.float_duration;
        next_cfg.standstill_emf_threshold = sd.standstill_emf_threshold;
        next_cfg.reverse_active = sd.reverse_drive_enable;
        if (sd.reverse_drive_enable) begin
            next_cfg.reverse_handoff_speed = sd.reverse_handoff_speed;
            next_cfg.reverse_open_loop_current_limit =
                sd.reverse_open_loop_current_limit;
            next_cfg.reverse_linear_accel = rd.reverse_linear_accel;
            next_cfg.reverse_quadratic_accel =
                rd.reverse_quadratic_accel;
        end
        next_cfg.braking_current_limit = rd.braking_current_limit;
        next_cfg.braking_prop_gain = rd.braking_prop_gain;
        next_cfg.braking_integral_gain = rd.braking_integral_gain;
        next_cfg.startup_method = msr_startup_t'(su.startup_method);
        next_cfg.ramp_rate = su.ramp_rate;
        next_cfg.ramp_unlimited = su.ramp_rate == `MSR_RAMP_FREE;
        next_cfg.align_time = su.align_time;
        // Ambiguous table entries are flagged, never mapped to a value
        next_cfg.code_unresolved =
            (rd.reverse_quadratic_accel == `MSR_QACC_DUP) ||
            (su.ramp_rate >= `MSR_RAMP_DUP_LO &&
             su.ramp_rate <= `MSR_RAMP_DUP_HI);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= '0;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Reverse handoff, open-loop current and accel codes read zero while reverse drive is off
    a_rev_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !sd.reverse_drive_enable |=>
        cfg.reverse_handoff_speed == '0 &&
        cfg.reverse_open_loop_current_limit == '0 &&
        cfg.reverse_linear_accel == '0 &&
        cfg.reverse_quadratic_accel == '0)
        else $error("reverse fields leak while disabled");
    a_rev_pass: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sd.reverse_drive_enable |=>
        cfg.reverse_handoff_speed == $past(sd.reverse_handoff_speed) &&
        cfg.reverse_open_loop_current_limit ==
        $past(sd.reverse_open_loop_current_limit) &&
        cfg.reverse_linear_accel == $past(rd.reverse_linear_accel) &&
        cfg.reverse_quadratic_accel == $past(rd.reverse_quadratic_accel))
        else $error("reverse fields not forwarded");
    a_brake_en: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg.brake_active == $past(sd.brake_enable))
        else $error("brake enable not tracked");
    a_float_en: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg.float_active == $past(sd.float_phase_enable))
        else $error("float enable not tracked");
    a_stop_fields: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg.brake_hold_duration == $past(sd.brake_hold_duration) &&
        cfg.float_duration == $past(sd.float_duration) &&
        cfg.standstill_emf_threshold == $past(sd.standstill_emf_threshold))
        else $error("stop sequence fields not forwarded");
    a_start_fields: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg.braking_current_limit == $past(rd.braking_current_limit) &&
        cfg.align_time == $past(su.align_time))
        else $error("limit or align code not forwarded");
    a_ramp_free: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg.ramp_unlimited == (cfg.ramp_rate == `MSR_RAMP_FREE))
        else $error("ramp unlimited on wrong code");
    a_write_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && hwrite && hsize == `MSR_HSIZE_WORD && a8 == `MSR_IDX_RD
        |-> ##2 rd == $past(hwdata, 1))
        else $error("write to reverse register lost");
    // Narrow or unmapped writes must leave every register alone
    a_write_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && hwrite && (hsize != `MSR_HSIZE_WORD ||
        (a8 != `MSR_IDX_SD && a8 != `MSR_IDX_RD && a8 != `MSR_IDX_SU))
        |-> ##2 $stable(sd) && $stable(rd) && $stable(su))
        else $error("refused write changed a register");
    a_read_back: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && a8 == `MSR_IDX_SU |=> hrdata == $past(su))
        else $error("startup register read back wrong");
    a_method_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(su.startup_method) |=>
        cfg.startup_method == $past(su.startup_method))
        else $error("startup method not forwarded");
    a_gain_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 cfg.braking_prop_gain == $past(rd.braking_prop_gain)
        && cfg.braking_integral_gain == $past(rd.braking_integral_gain))
        else $error("braking gains not forwarded");
    a_unres_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd.reverse_quadratic_accel == `MSR_QACC_DUP |=> cfg.code_unresolved)
        else $error("duplicate code not flagged");
    // Ramp code C is printed with two values, D and E not at all
    a_unres_ramp: assert property (
        @(posedge hclk) disable iff (!hresetn)
        su.ramp_rate inside {[`MSR_RAMP_DUP_LO:`MSR_RAMP_DUP_HI]}
        |=> cfg.code_unresolved)
        else $error("unresolved ramp code not flagged");
    a_unres_only: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd.reverse_quadratic_accel != `MSR_QACC_DUP &&
        !(su.ramp_rate inside {[`MSR_RAMP_DUP_LO:`MSR_RAMP_DUP_HI]})
        |=> !cfg.code_unresolved)
        else $error("resolved code flagged");
endmodule : msr_bank

// file: tb/tb.sv
`timescale 1ns/10ps
`include "msr_regs.svh"
module tb;
    import msr_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [31:0] v [3];
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    msr_cfg_t    cfg;
    int          err_count;
    int          num_checks;
    int          seed;
    // Byte address is four times the register index
    logic [31:0] adr [3] = '{{22'h0, `MSR_IDX_SD, 2'h0},
                             {22'h0, `MSR_IDX_RD, 2'h0},
                             {22'h0, `MSR_IDX_SU, 2'h0}};
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    msr_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cfg(cfg));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait: a stuck ready ends the run instead of hanging
    task automatic wait_rdy();
        int n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 50) begin
            err_count++;
            end_of_test();
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, input logic [2:0] sz,
                        output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        hsize  <= sz;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : xfer
    // Reverse fields masked when reverse drive is off
    function automatic msr_cfg_t exp_cfg(input logic [31:0] s,
                                         input logic [31:0] r,
                                         input logic [31:0] u);
        logic e;
        logic q;
        e = s[27];
        q = r[26:23] == 4'hE || u[28:25] inside {4'hC, 4'hD, 4'hE};
        return {s[29], s[16:13], s[28], s[12:9], s[8:6], e,
                s[5:2] & {4{e}}, s[1:0] & {2{e}}, r[30:23] & {8{e}},
                r[22:0], u[30:25], u[28:25] == 4'hF, u[24:21], q};
    endfunction : exp_cfg
    initial begin
        seed = 32'h9F40;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = `MSR_HSIZE_WORD;
        hwdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(cfg, 64'h0);
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, adr[k], 32'h0, `MSR_HSIZE_WORD, rd);
            chk(rd, 64'h0);
        end
        for (int i = 0; i < 16; i++) begin
            v[0] = (i == 15) ? 32'hFFFF_FFFF : $random(seed);
            v[1] = $random(seed);
            v[2] = $random(seed);
            v[0][27] = i[0];
            v[1][26:23] = i[3:0];
            v[2][28:25] = i[3:0];
            v[2][30:29] = i[1:0];
            for (int k = 0; k < 3; k++) begin
                xfer(1'b1, adr[k], v[k], `MSR_HSIZE_WORD, rd);
            end
            for (int k = 0; k < 3; k++) begin
                xfer(1'b0, adr[k], 32'h0, `MSR_HSIZE_WORD, rd);
                chk(rd, v[k]);
            end
            chk(cfg, exp_cfg(v[0], v[1], v[2]));
        end
        // Unmapped place and a byte-sized write must leave no mark
        xfer(1'b1, 32'h218, 32'hA5A5_5A5A, `MSR_HSIZE_WORD, rd);
        xfer(1'b0, 32'h218, 32'h0, `MSR_HSIZE_WORD, rd);
        chk(rd, 64'h0);
        chk({hreadyout, hresp}, 64'h2);
        xfer(1'b1, adr[1], 32'h1234_5678, 3'h0, rd);
        xfer(1'b0, adr[1], 32'h0, `MSR_HSIZE_WORD, rd);
        chk(rd, v[1]);
        repeat (2) @(posedge hclk);
        chk(cfg, exp_cfg(v[0], v[1], v[2]));
        // Mid-run reset must clear the speed-detect register and the outputs
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(cfg, 64'h0);
        xfer(1'b0, adr[0], 32'h0, `MSR_HSIZE_WORD, rd);
        chk(rd, 64'h0);
        end_of_test();
    end
endmodule : tb
